// File: common/scg_pkg.sv
// Constants and carrier types for the system clock select and gating block
package scg_pkg;

   localparam int ADDR_W = 8;

   localparam logic [ADDR_W-1:0] OFF_SYS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_DEV_GATE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h80;

   localparam int SRC_LSB = 0;
   localparam int SRC_MSB = 1;
   localparam int CPU_LSB = 4;
   localparam int CPU_MSB = 5;
   localparam int BUS_BIT = 8;

   localparam logic [31:0] SYS_WR_MASK  = 32'h0000_0133;
   localparam logic [31:0] DEV_WR_MASK  = 32'h7BFF_FFF7;
   localparam logic [31:0] SYS_RST_VAL  = 32'h0000_0000;
   localparam logic [31:0] DEV_RST_VAL  = 32'h0000_0000;
   // Bus divider end count after reset: /2, since the bus never runs undivided
   localparam logic [2:0]  BUS_LAST_RST = 3'h1;

   // Status layout: active source, active processor and bus divider ends
   localparam int STA_SRC_LSB = 0;
   localparam int STA_CPU_LSB = 4;
   localparam int STA_BUS_LSB = 8;

   typedef enum logic [1:0] {
      SRC_SLOW_32K = 2'b00,
      SRC_HF_OSC   = 2'b01,
      SRC_ROOT_PLL = 2'b10,
      SRC_FIX_52M  = 2'b11
   } scg_src_t;

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
   } scg_bus_req_t;

   typedef struct packed {
      logic resv31;
      logic radioDigitalGate;
      logic modemGate;
      logic basebandGate;
      logic basebandTickGate;
      logic resv26;
      logic pulseWidthGate;
      logic lowRateConverterGate;
      logic voiceDetectGate;
      logic tunerGate;
      logic infraredGate;
      logic usbControllerGate;
      logic timerThreeGate;
      logic timerTwoGate;
      logic timerOneGate;
      logic timerZeroGate;
      logic secondSpiGate;
      logic firstSpiGate;
      logic secondTwoWireGate;
      logic firstTwoWireGate;
      logic segmentDisplayGate;
      logic matrixDisplayGate;
      logic secondCardGate;
      logic firstCardGate;
      logic secondSerialGate;
      logic firstSerialGate;
      logic audioRxMasterGate;
      logic audioTxMasterGate;
      logic resv3;
      logic audioOutConverterGate;
      logic audioInConverterGate;
      logic dmaGate;
   } scg_dev_gate_t;

endpackage : scg_pkg

// File: core/scg_divider.sv
// Tick divider that changes ratio only at a period boundary or on a restart
`timescale 1ns/1ps
module scg_divider #(
   parameter int               CNT_W    = 3,
   parameter logic [CNT_W-1:0] RST_LAST = '0
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             restart,
   input  wire logic             tick,
   input  wire logic [CNT_W-1:0] lastIn,
   output logic      [CNT_W-1:0] lastActive,
   output logic                  pulse
);
   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q      <= '0;
         // Reset ratio is a parameter so a divider can never start below its minimum
         lastActive <= RST_LAST;
      end
      else if (restart)
      begin
         cnt_q      <= '0;
         lastActive <= lastIn;
      end
      else if (tick)
      begin
         if (cnt_q == lastActive)
         begin
            cnt_q      <= '0;
            // New ratio at the wrap, so only a restart ever cuts a period short
            lastActive <= lastIn;
         end
         else
         begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pulse <= 1'b0;
      else
         pulse <= tick && !restart && (cnt_q == lastActive);
   end

endmodule : scg_divider

// File: core/scg_top.sv
// Root source select, processor and bus dividers, per-device clock gates
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module scg_top (
   input  wire logic                   core_clk,
   input  wire logic                   sys_rst,
   input  wire scg_pkg::scg_bus_req_t  busReq,
   output logic      [31:0]            regRdata,
   input  wire logic [3:0]             rootTicks,
   output logic                        rootClkEn,
   output logic                        cpuClkEn,
   output logic                        busClkEn,
   output scg_pkg::scg_dev_gate_t      devGates
);
   import scg_pkg::*;

   logic [31:0] sysReg_q;
   logic [31:0] devReg_q;
   logic [1:0]  rootSel_q;
   logic        rootTick_q;
   logic        switchNow;
   logic [1:0]  reqSrc;
   logic [2:0]  cpuLastReq;
   logic [2:0]  cpuLastAct;
   logic [2:0]  busLastReq;
   logic [2:0]  busLastAct;
   logic        cpuPulse;
   logic        busPulse;
   logic [31:0] rdMux;

   // Divider end count for a 2**code ratio
   function automatic logic [2:0] pow2Last(input logic [1:0] code);
      pow2Last = 3'((4'h1 << code) - 4'h1);
   endfunction : pow2Last

   // Register writes; reserved bits are masked so they can never steer a clock
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         sysReg_q <= SYS_RST_VAL;
      else if (busReq.wr && busReq.addr == OFF_SYS_CTRL)
         sysReg_q <= busReq.wdata & SYS_WR_MASK;
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         devReg_q <= DEV_RST_VAL;
      else if (busReq.wr && busReq.addr == OFF_DEV_GATE)
         devReg_q <= busReq.wdata & DEV_WR_MASK;
   end

   assign reqSrc     = sysReg_q[SRC_MSB:SRC_LSB];
   assign cpuLastReq = pow2Last(sysReg_q[CPU_MSB:CPU_LSB]);
   assign busLastReq = sysReg_q[BUS_BIT] ? pow2Last(2'b10) : pow2Last(2'b01);

   // Source changes only in a cycle where the old source is idle,
   // so the last old pulse is never merged with a new one
   assign switchNow = (rootSel_q != reqSrc) && !rootTicks[rootSel_q];

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         rootSel_q <= SRC_SLOW_32K;
      else if (switchNow)
         rootSel_q <= reqSrc;
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         rootTick_q <= 1'b0;
      else
         rootTick_q <= rootTicks[rootSel_q];
   end

   // Divider counters restart with the new source so its first period is whole
   scg_divider #(.CNT_W(3)) u_cpuDiv (
      .clk        (core_clk),
      .rst        (sys_rst),
      .restart    (switchNow),
      .tick       (rootTick_q),
      .lastIn     (cpuLastReq),
      .lastActive (cpuLastAct),
      .pulse      (cpuPulse)
   );

   scg_divider #(.CNT_W(3), .RST_LAST(BUS_LAST_RST)) u_busDiv (
      .clk        (core_clk),
      .rst        (sys_rst),
      .restart    (switchNow),
      .tick       (rootTick_q),
      .lastIn     (busLastReq),
      .lastActive (busLastAct),
      .pulse      (busPulse)
   );

   assign rootClkEn = rootTick_q;
   assign cpuClkEn  = cpuPulse;
   assign busClkEn  = busPulse;

   // Whole-cycle enable pulses, registered, so an enable flip cannot cut one
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         devGates <= '0;
      else
         devGates <= scg_dev_gate_t'({32{rootTick_q}} & devReg_q);
   end

   always_comb
   begin
      rdMux = 32'h0000_0000;
      case (busReq.addr)
         OFF_SYS_CTRL: rdMux = sysReg_q;
         OFF_DEV_GATE: rdMux = devReg_q;
         OFF_STATUS:
         begin
            rdMux[STA_SRC_LSB +: 2] = rootSel_q;
            rdMux[STA_CPU_LSB +: 3] = cpuLastAct;
            rdMux[STA_BUS_LSB +: 3] = busLastAct;
         end
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         regRdata <= 32'h0000_0000;
      else if (busReq.rd)
         regRdata <= rdMux;
      else
         regRdata <= 32'h0000_0000;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_root_switch;
      (rootSel_q != reqSrc && !rootTicks[rootSel_q]) |=> rootSel_q == $past(reqSrc);
   endproperty
   a_root_switch: assert property (p_root_switch)
      else $error("root source did not follow select field");

   property p_root_hold;
      rootTicks[rootSel_q] |=> rootSel_q == $past(rootSel_q);
   endproperty
   a_root_hold: assert property (p_root_hold)
      else $error("root source changed during an active pulse");

   property p_cpu_div8;
      (cpuClkEn && cpuLastAct == 3'h7) |=> !cpuClkEn [*7];
   endproperty
   a_cpu_div8: assert property (p_cpu_div8)
      else $error("processor pulse spacing shorter than eight");

   property p_cpu_undiv;
      (rootTick_q && cpuLastAct == 3'h0 && !switchNow) |=> cpuClkEn;
   endproperty
   a_cpu_undiv: assert property (p_cpu_undiv)
      else $error("undivided processor clock missed a root pulse");

   property p_bus_div2;
      (busClkEn && busLastAct == 3'h1) |=> !busClkEn;
   endproperty
   a_bus_div2: assert property (p_bus_div2)
      else $error("bus pulse spacing shorter than two");

   property p_bus_min;
      busLastAct == 3'h1 || busLastAct == 3'h3;
   endproperty
   a_bus_min: assert property (p_bus_min)
      else $error("bus divider ratio is neither two nor four");

   property p_gate_pulse;
      (|devGates) |-> $past(rootTick_q);
   endproperty
   a_gate_pulse: assert property (p_gate_pulse)
      else $error("gated clock pulse without a root pulse");

   property p_gate_dma;
      (rootTick_q && devReg_q[0]) |=> devGates.dmaGate;
   endproperty
   a_gate_dma: assert property (p_gate_dma)
      else $error("enabled dma clock missed a pulse");

   property p_gate_off;
      !devReg_q[30] |=> !devGates.radioDigitalGate;
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("radio digital clock ran while disabled");

   property p_gate_radio;
      devGates.radioDigitalGate == $past(rootTick_q && devReg_q[30]);
   endproperty
   a_gate_radio: assert property (p_gate_radio)
      else $error("radio digital clock does not follow its enable");

   property p_gate_modem;
      devGates.modemGate == $past(rootTick_q && devReg_q[29]);
   endproperty
   a_gate_modem: assert property (p_gate_modem)
      else $error("modem clock does not follow its enable");

   property p_gate_baseband;
      devGates.basebandGate == $past(rootTick_q && devReg_q[28]);
   endproperty
   a_gate_baseband: assert property (p_gate_baseband)
      else $error("baseband clock does not follow its enable");

   property p_gate_tick;
      devGates.basebandTickGate == $past(rootTick_q && devReg_q[27]);
   endproperty
   a_gate_tick: assert property (p_gate_tick)
      else $error("baseband tick clock does not follow its enable");

   property p_gate_pwm;
      devGates.pulseWidthGate == $past(rootTick_q && devReg_q[25]);
   endproperty
   a_gate_pwm: assert property (p_gate_pwm)
      else $error("pulse width clock does not follow its enable");

   property p_gate_lowrate;
      devGates.lowRateConverterGate == $past(rootTick_q && devReg_q[24]);
   endproperty
   a_gate_lowrate: assert property (p_gate_lowrate)
      else $error("low rate converter clock does not follow its enable");

   property p_gate_voice;
      devGates.voiceDetectGate == $past(rootTick_q && devReg_q[23]);
   endproperty
   a_gate_voice: assert property (p_gate_voice)
      else $error("voice detector clock does not follow its enable");

   property p_gate_tuner_ir;
      {devGates.tunerGate, devGates.infraredGate}
         == $past({2{rootTick_q}} & devReg_q[22:21]);
   endproperty
   a_gate_tuner_ir: assert property (p_gate_tuner_ir)
      else $error("tuner or infrared clock does not follow its enable");

   property p_gate_usb;
      devGates.usbControllerGate == $past(rootTick_q && devReg_q[20]);
   endproperty
   a_gate_usb: assert property (p_gate_usb)
      else $error("usb controller clock does not follow its enable");

   property p_gate_timers;
      {devGates.timerThreeGate, devGates.timerTwoGate, devGates.timerOneGate,
       devGates.timerZeroGate} == $past({4{rootTick_q}} & devReg_q[19:16]);
   endproperty
   a_gate_timers: assert property (p_gate_timers)
      else $error("timer clock does not follow its enable");

   property p_gate_spi;
      {devGates.secondSpiGate, devGates.firstSpiGate}
         == $past({2{rootTick_q}} & devReg_q[15:14]);
   endproperty
   a_gate_spi: assert property (p_gate_spi)
      else $error("spi clock does not follow its enable");

   property p_gate_two_wire;
      {devGates.secondTwoWireGate, devGates.firstTwoWireGate}
         == $past({2{rootTick_q}} & devReg_q[13:12]);
   endproperty
   a_gate_two_wire: assert property (p_gate_two_wire)
      else $error("two-wire clock does not follow its enable");

   property p_gate_segment;
      devGates.segmentDisplayGate == $past(rootTick_q && devReg_q[11]);
   endproperty
   a_gate_segment: assert property (p_gate_segment)
      else $error("segment display clock does not follow its enable");

   property p_gate_matrix;
      devGates.matrixDisplayGate == $past(rootTick_q && devReg_q[10]);
   endproperty
   a_gate_matrix: assert property (p_gate_matrix)
      else $error("matrix display clock does not follow its enable");

   property p_gate_card;
      {devGates.secondCardGate, devGates.firstCardGate}
         == $past({2{rootTick_q}} & devReg_q[9:8]);
   endproperty
   a_gate_card: assert property (p_gate_card)
      else $error("card controller clock does not follow its enable");

   property p_gate_serial;
      {devGates.secondSerialGate, devGates.firstSerialGate}
         == $past({2{rootTick_q}} & devReg_q[7:6]);
   endproperty
   a_gate_serial: assert property (p_gate_serial)
      else $error("serial clock does not follow its enable");

   property p_gate_audio_master;
      {devGates.audioRxMasterGate, devGates.audioTxMasterGate}
         == $past({2{rootTick_q}} & devReg_q[5:4]);
   endproperty
   a_gate_audio_master: assert property (p_gate_audio_master)
      else $error("audio master clock does not follow its enable");

   property p_gate_converter;
      {devGates.audioOutConverterGate, devGates.audioInConverterGate}
         == $past({2{rootTick_q}} & devReg_q[2:1]);
   endproperty
   a_gate_converter: assert property (p_gate_converter)
      else $error("audio converter clock does not follow its enable");

   property p_resv_read;
      (busReq.rd && busReq.addr == OFF_DEV_GATE)
         |=> (regRdata[31] == 1'b0 && regRdata[26] == 1'b0 && regRdata[3] == 1'b0);
   endproperty
   a_resv_read: assert property (p_resv_read)
      else $error("reserved device gate bit read as one");

   property p_wr_sys;
      (busReq.wr && busReq.addr == OFF_SYS_CTRL)
         |=> sysReg_q == ($past(busReq.wdata) & SYS_WR_MASK);
   endproperty
   a_wr_sys: assert property (p_wr_sys)
      else $error("system control write not stored as masked");

   property p_wr_dev;
      (busReq.wr && busReq.addr == OFF_DEV_GATE)
         |=> devReg_q == ($past(busReq.wdata) & DEV_WR_MASK);
   endproperty
   a_wr_dev: assert property (p_wr_dev)
      else $error("device gate write not stored as masked");

   property p_resv_sys;
      (busReq.rd && busReq.addr == OFF_SYS_CTRL)
         |=> (regRdata & ~SYS_WR_MASK) == 32'h0000_0000;
   endproperty
   a_resv_sys: assert property (p_resv_sys)
      else $error("reserved system control bit read as one");

   // A ratio may only move at a wrap or with a source restart
   property p_cpu_wrap;
      $changed(cpuLastAct) |-> $past(switchNow) || cpuClkEn;
   endproperty
   a_cpu_wrap: assert property (p_cpu_wrap)
      else $error("processor ratio changed inside a period");

   property p_bus_wrap;
      $changed(busLastAct) |-> $past(switchNow) || busClkEn;
   endproperty
   a_bus_wrap: assert property (p_bus_wrap)
      else $error("bus ratio changed inside a period");

   c_switch:  cover property (switchNow ##1 rootSel_q == SRC_FIX_52M);
   c_cpu8:    cover property (cpuClkEn && cpuLastAct == 3'h7);
   c_bus4:    cover property (busClkEn && busLastAct == 3'h3);
   c_dmaGate: cover property (devGates.dmaGate);

endmodule : scg_top

// File: tb/scg_root_src.sv
// Behavioural root sources: four pulse trains at set spacings that slowMode doubles
`timescale 1ns/1ps
module scg_root_src (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       slowMode,
   output logic      [3:0] rootTicks
);
   // Spacing of two or more leaves the low cycle a source switch waits for
   localparam int SPACE [4] = '{5, 3, 2, 4};
   int cnt [4];
   always @(posedge core_clk or posedge sys_rst)
      for (int i = 0; i < 4; i++)
      begin
         rootTicks[i] <= !sys_rst && cnt[i] == 0;
         cnt[i] <= (sys_rst || cnt[i] + 1 >= (SPACE[i] << slowMode)) ? 0 : cnt[i] + 1;
      end
endmodule : scg_root_src

// File: tb/system_clock_select_and_gating_tb.sv
// Self-checking bench for root select, dividers and device clock gates
`timescale 1ns/1ps
module system_clock_select_and_gating_tb;
   import scg_pkg::*;
   logic          core_clk = 1'b0;
   logic          sys_rst  = 1'b1;
   logic          slowMode = 1'b0;
   scg_bus_req_t  busReq   = '0;
   logic   [31:0] regRdata;
   logic   [3:0]  rootTicks;
   logic          rootClkEn;
   logic          cpuClkEn;
   logic          busClkEn;
   scg_dev_gate_t devGates;
   wire    [31:0] gatesSeen = devGates;
   logic   [31:0] rndState  = 32'h9DC24641;
   logic   [31:0] expGates  = '0;
   logic   [31:0] sysVal;
   logic   [31:0] expRd;
   logic   [31:0] expQ [$];
   logic          measure   = 1'b0;
   logic          rdLast    = 1'b0;
   logic          rootLast  = 1'b0;
   logic   [3:0]  tickLast  = '0;
   int            mismatches = 0;
   int            checks     = 0;
   int            expSrc = 0;
   int            expCpu = 1;
   int            expBus = 2;
   int            cpuCnt = -1;
   int            busCnt = -1;

   always #50 core_clk = ~core_clk;

   scg_top scg_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .busReq(busReq),
      .regRdata(regRdata), .rootTicks(rootTicks), .rootClkEn(rootClkEn),
      .cpuClkEn(cpuClkEn), .busClkEn(busClkEn), .devGates(devGates));
   scg_root_src scg_root_src_inst (.core_clk(core_clk), .sys_rst(sys_rst),
      .slowMode(slowMode), .rootTicks(rootTicks));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   task automatic note_bad(input string what, input logic [31:0] e, input logic [31:0] s);
      $display("unexpected %s expected %h seen %h", what, e, s);
      mismatches++;
   endtask : note_bad

   // Called right after a rising edge; returns at the edge that takes the request
   task automatic bus_op(input logic rd, input logic wr, input logic [ADDR_W-1:0] addr,
                         input logic [31:0] data);
      busReq <= '{rd: rd, wr: wr, addr: addr, wdata: data};
      @(posedge core_clk);
   endtask : bus_op

   task automatic rd_chk(input logic [ADDR_W-1:0] addr, input logic [31:0] e);
      expQ.push_back(e);
      bus_op(1'b1, 1'b0, addr, '0);
   endtask : rd_chk

   // Counts root pulses between divided pulses; -1 means no pulse seen yet
   task automatic ratio_chk(input string what, input logic pulse, input int e, inout int cnt);
      if (pulse === 1'b1)
      begin
         if (cnt >= 0)
         begin
            checks++;
            if (cnt != e) note_bad(what, 32'(e), 32'(cnt));
         end
         cnt = int'(rootClkEn);
      end
      else if (cnt >= 0)
         cnt += int'(rootClkEn);
   endtask : ratio_chk

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict

   // Outputs are settled mid-cycle, so all watching happens on the falling edge
   always @(negedge core_clk)
   begin
      if (rdLast)
      begin
         expRd = expQ.pop_front();
         checks++;
         if (regRdata !== expRd) note_bad("read data", expRd, regRdata);
      end
      if (measure)
      begin
         checks++;
         if (rootClkEn !== tickLast[expSrc]) note_bad("root", 32'(tickLast[expSrc]), 32'(rootClkEn));
         checks++;
         if (gatesSeen !== (rootLast ? expGates : '0)) note_bad("gates", expGates, gatesSeen);
         ratio_chk("cpu ratio", cpuClkEn, expCpu, cpuCnt);
         ratio_chk("bus ratio", busClkEn, expBus, busCnt);
      end
      rdLast = busReq.rd;
      rootLast = rootClkEn;
      tickLast = rootTicks;
   end

   initial
   begin
      #(40000 * 100);
      mismatches++;
      print_verdict();
   end

   initial
   begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd_chk(OFF_SYS_CTRL, SYS_RST_VAL);
      rd_chk(OFF_DEV_GATE, DEV_RST_VAL);
      bus_op(1'b0, 1'b1, OFF_SYS_CTRL, 32'hFFFFFFFF);
      bus_op(1'b0, 1'b1, OFF_DEV_GATE, 32'hFFFFFFFF);
      bus_op(1'b0, 1'b1, 8'h08, 32'hFFFFFFFF);
      rd_chk(OFF_SYS_CTRL, SYS_WR_MASK);
      rd_chk(OFF_DEV_GATE, DEV_WR_MASK);
      rd_chk(8'h08, 32'h00000000);
      bus_op(1'b0, 1'b0, '0, '0);
      $display("reset and reserved bits test done");
      // Every source, processor ratio and bus ratio, with random gates
      for (int c = 0; c < 32; c++)
      begin
         rndState = xorshift(rndState);
         slowMode <= rndState[31];
         expSrc = c % 4;
         expCpu = 1 << ((c / 4) % 4);
         expBus = c >= 16 ? 4 : 2;
         expGates = rndState & DEV_WR_MASK;
         sysVal = 32'(c % 4) | (32'((c / 4) % 4) << 4) | (32'(c / 16) << 8);
         bus_op(1'b0, 1'b1, OFF_SYS_CTRL, sysVal | (rndState & ~SYS_WR_MASK));
         bus_op(1'b0, 1'b1, OFF_DEV_GATE, rndState);
         rd_chk(OFF_SYS_CTRL, sysVal);
         rd_chk(OFF_DEV_GATE, expGates);
         bus_op(1'b0, 1'b0, '0, '0);
         // Switch waits for a quiet cycle, and the new ratios load with the restart that the switch makes
         repeat (250) @(posedge core_clk);
         rd_chk(OFF_STATUS, sysVal[1:0] | (32'(expCpu - 1) << 4) | (32'(expBus - 1) << 8));
         bus_op(1'b0, 1'b0, '0, '0);
         cpuCnt = -1;
         busCnt = -1;
         measure <= 1'b1;
         repeat (400) @(posedge core_clk);
         measure <= 1'b0;
         checks++;
         if (cpuCnt < 0 || cpuCnt > expCpu) note_bad("cpu pending", 32'(expCpu), 32'(cpuCnt));
         checks++;
         if (busCnt < 0 || busCnt > expBus) note_bad("bus pending", 32'(expBus), 32'(busCnt));
      end
      $display("source, divider and gate test done");
      print_verdict();
   end
endmodule : system_clock_select_and_gating_tb
